// [shared/cdd_pkg.sv]
//==============================================================
package cdd_pkg;
    localparam logic [7:0] CAL_CTRL_ADDR = 8'h18;
    localparam logic [7:0] ZD_CTRL_ADDR = 8'h1e;
    localparam logic [7:0] STATUS_ADDR = 8'h1f;
    localparam int CAL_START_BIT = 0;
    localparam int CAL_DIV_LSB = 1;
    localparam int ZD_MODE_LSB = 1;
    localparam int ZD_SRC_LSB = 3;
    localparam int CAL_DONE_BIT = 6;
    localparam logic [7:0] CAL_CTRL_RESET = 8'h00;
    localparam logic [7:0] ZD_CTRL_RESET = 8'h00;
    localparam logic [1:0] ZD_INTERNAL = 2'h1;
    localparam logic [1:0] ZD_EXTERNAL = 2'h3;
    localparam int CAL_CYCLES = 4400;
    localparam int CNT_W = 4;
    localparam int NUM_CH = 4;
    localparam int PRE_W = 3;
endpackage

// [design/cdd_channel.sv]
`timescale 1ns/1ps
// one channel divider, stepped once per prescaled input cycle
module cdd_channel
    import cdd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic step,
    input wire logic hold,
    input wire logic [cdd_pkg::CNT_W-1:0] low_count,
    input wire logic [cdd_pkg::CNT_W-1:0] high_count,
    input wire logic bypass,
    input wire logic dcc_on,
    input wire logic [cdd_pkg::CNT_W-1:0] delay,
    input wire logic start_high,
    input wire logic in_level,
    output logic out
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] dly;
    logic phase_hi;
    logic half;
    // widened so that high_count of 15 cannot wrap onto a low_count of 0
    wire logic odd_fix = dcc_on && ({1'b0, low_count} == {1'b0, high_count} + 5'h01);
    wire logic [CNT_W-1:0] lim = phase_hi ? high_count : low_count;

    //==============================================================
    // counters; held in sync state resets to start level
    always_ff @(posedge ref_clk) begin
        if (rst || hold) begin
            cnt <= '0;
            dly <= delay;
            phase_hi <= start_high;
            half <= 1'b0;
        end else if (step) begin
            if (dly != '0) begin
                dly <= dly - 4'h1;
            end else if (cnt == lim) begin
                cnt <= '0;
                phase_hi <= ~phase_hi;
            end else begin
                cnt <= cnt + 4'h1;
            end
            half <= 1'b1;
        end
    end

    //==============================================================
    // duty correction: extend high by half an input cycle, using input level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out <= 1'b0;
        end else if (hold) begin
            out <= start_high;
        end else if (bypass) begin
            out <= in_level;
        end else if (odd_fix && !phase_hi && cnt == '0 && dly == '0 && half) begin
            out <= in_level; // first low cycle keeps high half
        end else begin
            out <= phase_hi;
        end
    end
endmodule // cdd_channel

// [design/cdd_top.sv]
`timescale 1ns/1ps
// distribution control: registers, prescaler, calibration timer, channels
module cdd_top
    import cdd_pkg::*;
#(
    parameter int CAL_CYCLES_P = cdd_pkg::CAL_CYCLES
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic div_in,
    input wire logic pd_tick,
    input wire logic [cdd_pkg::PRE_W-1:0] pre_ratio,
    input wire logic [cdd_pkg::NUM_CH*cdd_pkg::CNT_W-1:0] low_counts,
    input wire logic [cdd_pkg::NUM_CH*cdd_pkg::CNT_W-1:0] high_counts,
    input wire logic [cdd_pkg::NUM_CH-1:0] bypass,
    input wire logic [cdd_pkg::NUM_CH-1:0] dcc_disable,
    input wire logic [cdd_pkg::NUM_CH*cdd_pkg::CNT_W-1:0] delays,
    input wire logic [cdd_pkg::NUM_CH-1:0] start_high,
    input wire logic sync_req,
    input wire logic ext_fb_in,
    output logic [cdd_pkg::NUM_CH-1:0] ch_out,
    output logic fb_out,
    output logic in_sync,
    output logic cal_busy
);
    import cdd_pkg::*;

    typedef enum logic [1:0] {
        CDD_IDLE = 2'b01,
        CDD_CAL = 2'b10
    } cdd_state_t;

    cdd_state_t state;
    logic [7:0] cal_ctrl;
    logic [7:0] zd_ctrl;
    logic cal_done;
    logic start_prev;
    logic [12:0] cal_cnt;
    logic [4:0] cal_div_cnt;
    logic [PRE_W-1:0] pre_cnt;
    logic div_prev;
    logic pre_level;
    logic [NUM_CH-1:0] ch_raw;

    //==============================================================
    // register decode
    wire logic wr_cal = clk_en && reg_wr && reg_addr == CAL_CTRL_ADDR;
    wire logic wr_zd = clk_en && reg_wr && reg_addr == ZD_CTRL_ADDR;
    wire logic [1:0] cal_div_sel = cal_ctrl[CAL_DIV_LSB +: 2];
    wire logic [4:0] cal_div_max = 5'((5'h2 << cal_div_sel) - 5'h1); // 2,4,8,16
    wire logic [1:0] zd_mode = zd_ctrl[ZD_MODE_LSB +: 2];
    wire logic [1:0] zd_src = zd_ctrl[ZD_SRC_LSB +: 2];
    wire logic zd_int = zd_mode == ZD_INTERNAL;
    wire logic zd_ext = zd_mode == ZD_EXTERNAL;
    // rising edge of start bit only; settings changes never start one
    wire logic cal_req = wr_cal && reg_wdata[CAL_START_BIT] && !start_prev;
    wire logic cal_tick = pd_tick && cal_div_cnt == cal_div_max;
    wire logic cal_last = state == CDD_CAL && cal_tick && cal_cnt == 13'(CAL_CYCLES_P - 1);
    wire logic hold = sync_req || state == CDD_CAL;
    wire logic in_edge = div_in && !div_prev;
    wire logic pre_wrap = pre_cnt >= pre_ratio - 3'h1 || pre_ratio == '0;
    wire logic step = clk_en && in_edge && pre_wrap;
    wire logic dcc_allowed = pre_ratio > 3'h1;
    wire logic [7:0] status = {1'b0, cal_done, 6'h00};
    wire logic [7:0] next_rdata = reg_addr == CAL_CTRL_ADDR ? cal_ctrl :
                                  reg_addr == ZD_CTRL_ADDR ? zd_ctrl :
                                  reg_addr == STATUS_ADDR ? status : 8'h00;
    wire logic fb_int_src = ch_raw[0];
    wire logic next_fb = zd_int ? fb_int_src : zd_ext ? ext_fb_in : 1'b0;

    //==============================================================
    // registers and readback
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cal_ctrl <= CAL_CTRL_RESET;
            zd_ctrl <= ZD_CTRL_RESET;
            start_prev <= 1'b0;
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (wr_cal) begin
                cal_ctrl <= reg_wdata;
                start_prev <= reg_wdata[CAL_START_BIT];
            end
            if (wr_zd) begin
                zd_ctrl <= reg_wdata;
            end
            reg_rdata <= next_rdata;
        end
    end

    //==============================================================
    // calibration timer: counts calibration clock ticks while busy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= CDD_IDLE;
            cal_cnt <= '0;
            cal_div_cnt <= '0;
            cal_done <= 1'b0;
        end else if (clk_en) begin
            if (pd_tick) begin
                cal_div_cnt <= cal_tick ? 5'h00 : cal_div_cnt + 5'h01;
            end
            unique case (state)
                CDD_IDLE: begin
                    if (cal_req) begin
                        state <= CDD_CAL;
                        cal_cnt <= '0;
                        cal_done <= 1'b0;
                        cal_div_cnt <= '0;
                    end
                end
                CDD_CAL: begin
                    if (cal_last) begin
                        state <= CDD_IDLE;
                        cal_done <= 1'b1;
                    end else if (cal_tick) begin
                        cal_cnt <= cal_cnt + 13'h0001;
                    end
                end
                default: begin
                    state <= CDD_IDLE;
                end
            endcase
        end
    end

    //==============================================================
    // prescaler: counts rising edges of the divider input
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pre_cnt <= '0;
            div_prev <= 1'b0;
            pre_level <= 1'b0;
        end else if (clk_en) begin
            div_prev <= div_in;
            if (in_edge) begin
                pre_cnt <= pre_wrap ? '0 : pre_cnt + 3'h1;
            end
            pre_level <= pre_ratio <= 3'h1 ? div_in : pre_cnt < (pre_ratio >> 1);
        end
    end

    //==============================================================
    // four channels, each with its own divider; all share one prescaler
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        cdd_channel u_ch (
            .ref_clk(ref_clk),
            .rst(rst),
            .step(step),
            .hold(hold),
            .low_count(low_counts[i*CNT_W +: CNT_W]),
            .high_count(high_counts[i*CNT_W +: CNT_W]),
            .bypass(bypass[i]),
            .dcc_on(!dcc_disable[i] && dcc_allowed),
            .delay(delays[i*CNT_W +: CNT_W]),
            .start_high(start_high[i]),
            .in_level(pre_level),
            .out(ch_raw[i])
        );
    end

    //==============================================================
    // outputs re-registered so every port comes from a flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ch_out <= '0;
            fb_out <= 1'b0;
            in_sync <= 1'b0;
            cal_busy <= 1'b0;
        end else if (clk_en) begin
            ch_out <= ch_raw;
            fb_out <= next_fb;
            in_sync <= hold;
            cal_busy <= state == CDD_CAL;
        end
    end
endmodule // cdd_top

// [verif/cdd_props.sv]
`timescale 1ns/1ps
//==========================================================
// calibration, sync and feedback checks on the cdd_top ports
module cdd_props
    import cdd_pkg::*;
#(
    parameter int CAL_CYCLES_P = 8
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic pd_tick,
    input wire logic [cdd_pkg::NUM_CH-1:0] ch_out,
    input wire logic fb_out,
    input wire logic in_sync,
    input wire logic cal_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] cal_q, zd_q;
    int busy_n;
    wire wr_cal = clk_en && reg_wr && reg_addr == CAL_CTRL_ADDR;
    wire go = wr_cal && reg_wdata[CAL_START_BIT] && !cal_q[CAL_START_BIT] && !cal_busy;
    wire [1:0] zm = zd_q[ZD_MODE_LSB +: 2];
    wire mapped = reg_addr inside {CAL_CTRL_ADDR, ZD_CTRL_ADDR, STATUS_ADDR};
    // shadows keep the mode visible; phase ticks are counted, not cycles, so any rate works
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cal_q <= 8'h00;
            zd_q <= 8'h00;
            busy_n <= 0;
        end else if (clk_en) begin
            if (wr_cal)
                cal_q <= reg_wdata;
            if (reg_wr && reg_addr == ZD_CTRL_ADDR)
                zd_q <= reg_wdata;
            busy_n <= cal_busy ? busy_n + int'(pd_tick) : 0;
        end
    end
    sequence s_go; go ##1 clk_en [*2]; endsequence
    sequence s_held; cal_busy && in_sync; endsequence
    property p_start; s_go |-> s_held; endproperty
    property p_cause; $rose(cal_busy) |-> $past(go, 2); endproperty
    property p_sync; cal_busy |-> in_sync; endproperty
    property p_len; cal_busy |-> busy_n <= 16 * CAL_CYCLES_P + 2; endproperty
    property p_hold; in_sync [*5] |-> $stable(ch_out); endproperty
    property p_int;
        $rose(fb_out) && zm == ZD_INTERNAL && $past(zm, 3) == ZD_INTERNAL |-> ##[0:2] ch_out[0];
    endproperty
    property p_off; !zm[0] && !$past(zm[0], 3) |-> !fb_out; endproperty
    property p_unmap; $past(clk_en) && !$past(mapped) |-> reg_rdata == 8'h00; endproperty
    a_start: assert property (p_start) else $error("late calibration start");
    a_cause: assert property (p_cause) else $error("calibration without request");
    a_sync: assert property (p_sync) else $error("outputs not held in sync");
    a_len: assert property (p_len) else $error("calibration too long");
    a_hold: assert property (p_hold) else $error("outputs moved while held");
    a_int: assert property (p_int) else $error("feedback not from divider 0");
    a_off: assert property (p_off) else $error("feedback active while off");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // cdd_props
bind cdd_top cdd_props #(.CAL_CYCLES_P(CAL_CYCLES_P)) i_cdd_props (.*);

// [verif/cdd_host.sv]
`timescale 1ns/1ps
//==========================================================
// host end of the register port; calls start just after a rising edge
module cdd_host (
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // an idle edge after each write keeps two strobes from merging
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // readback is registered, so it is taken mid-cycle after the next edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask
endmodule // cdd_host

// [verif/cdd_top_tb_top.sv]
`timescale 1ns/1ps
//==========================================================
// bench: register reset, zero delay modes, channel division, calibration
module cdd_top_tb_top;
    import cdd_pkg::*;
    localparam int CP = 8;
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, div_in = 1'b0, pd_tick = 1'b0;
    logic sync_req = 1'b0, ext_fb_in = 1'b0, reg_wr, fb_out, in_sync, cal_busy;
    logic [2:0] pre_ratio = 3'h2;
    logic [15:0] low_counts = 16'h0f10, high_counts = 16'h0f20, delays = 16'h0000;
    logic [3:0] bypass = 4'h8, dcc_disable = 4'hf, start_high = 4'h0, ch_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    wire [4:0] obs = {fb_out, ch_out};
    cdd_top #(.CAL_CYCLES_P(CP)) i_cdd_top (.*);
    cdd_host i_cdd_host (.*);
    always #4 ref_clk = ~ref_clk;
    // divider input period 4, phase tick every 2, feedback input period 32
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        div_in <= cyc[1];
        pd_tick <= ~pd_tick;
        ext_fb_in <= cyc[4];
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %0h got %0h", n, e, g);
        end
    endtask
    // a window of whole periods makes high time and rise count phase-free
    task automatic count(input int c, input int w, output int hi, output int rs);
        logic p;
        hi = 0;
        rs = 0;
        p = obs[c];
        repeat (w) begin
            @(posedge ref_clk);
            hi += int'(obs[c] === 1'b1);
            rs += int'(obs[c] === 1'b1 && p === 1'b0);
            p = obs[c];
        end
    endtask
    task automatic t_reset();
        logic [7:0] a[4] = '{CAL_CTRL_ADDR, ZD_CTRL_ADDR, STATUS_ADDR, 8'h40};
        logic [7:0] d;
        foreach (a[i]) begin
            i_cdd_host.rd(a[i], d);
            chk("reset read", 8'h00, d);
        end
        $display("t_reset done");
    endtask
    task automatic t_zd();
        logic [7:0] d, v;
        int hi, rs;
        for (int m = 0; m < 4; m++) begin
            v = 8'(2 * m + ((m == 3) ? 16 : 0));
            i_cdd_host.wr(ZD_CTRL_ADDR, v);
            i_cdd_host.rd(ZD_CTRL_ADDR, d);
            chk("zd readback", v[4:1], d[4:1]);
            count(4, 64, hi, rs);
            chk("fb high", (m % 2) * 32, hi);
        end
        $display("t_zd done");
    endtask
    task automatic t_div();
        int hi_e[5] = '{8, 24, 128, 4, 12};
        int per_e[5] = '{16, 40, 256, 8, 24};
        int hi, rs;
        for (int i = 0; i < 5; i++) begin
            if (i == 4)
                pre_ratio <= 3'h3;
            repeat (64) @(posedge ref_clk);
            count(i % 4, 2 * per_e[i], hi, rs);
            chk("ch high", 2 * hi_e[i], hi);
            chk("ch rises", 2, rs);
        end
        $display("t_div done");
    endtask
    task automatic t_cal();
        logic [7:0] d;
        int n, e;
        for (int k = 0; k < 4; k++) begin
            e = 2 * CP * (2 << k);
            i_cdd_host.wr(CAL_CTRL_ADDR, 8'(2 * k));
            i_cdd_host.wr(CAL_CTRL_ADDR, 8'(2 * k + 1));
            n = 0;
            while (cal_busy !== 1'b1 && n < 9) begin
                @(posedge ref_clk);
                n++;
            end
            n = 0;
            while (cal_busy === 1'b1 && n < 9000) begin
                @(posedge ref_clk);
                n++;
            end
            chk("cal length ok", 1, n >= e - (4 << k) - 4 && n <= e + (4 << k) + 4);
            i_cdd_host.rd(STATUS_ADDR, d);
            chk("cal done", 1, d[CAL_DONE_BIT]);
            i_cdd_host.wr(CAL_CTRL_ADDR, 8'(2 * k + 1));
            repeat (4) @(posedge ref_clk);
            chk("no restart", 0, cal_busy);
        end
        $display("t_cal done");
    endtask
    // external sync: start levels, then a coarse delay of 3 prescaled steps (12 cycles each)
    task automatic t_sync();
        int n;
        start_high <= 4'h5;
        delays <= 16'h0003;
        sync_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("in sync", 1, in_sync);
        chk("start level", 4'h5, ch_out);
        sync_req <= 1'b0;
        n = 0;
        while (ch_out[0] === 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        chk("coarse delay", 1, n >= 38 && n <= 52);
        chk("sync released", 0, in_sync);
        delays <= 16'h0000;
        @(posedge ref_clk);
        $display("t_sync done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_zd();
        t_div();
        t_sync();
        t_cal();
        print_verdict();
    end
endmodule // cdd_top_tb_top
